// File: blsr_bias_leadoff_regs.sv
// Purpose: APB bank of bias-route and lead-off configuration registers
// Assumes: one clock, async active-low reset, zero-wait APB slave
// Notes:   absent channel bits are dropped on write and read as zero
//
// Behaviour
// - positive bias route register, reset zero
// - negative bias route register, reset zero
// - positive lead-off enable register, reset zero
// - negative lead-off enable register, reset zero
// - per-channel lead-off polarity swap register
// - four-channel parts lack bits five, four
// - four/six-channel parts lack bits seven, six
// - swap bit flips input pull directions
// - status reads one when electrode off
`timescale 1ns/1ps
`default_nettype none
module blsr_bias_leadoff_regs #(
  parameter logic [3:0] CHAN_COUNT = 4'h8
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  electrodeOffPos,
  input  wire logic [7:0]  electrodeOffNeg,
  output logic      [7:0]  biasRoutePos,
  output logic      [7:0]  biasRouteNeg,
  output logic      [7:0]  leadoffEnPos,
  output logic      [7:0]  leadoffEnNeg,
  output logic      [7:0]  pullPosToSupply,
  output logic      [7:0]  pullNegToSupply
);
  typedef struct packed {
    logic [7:0]  biasPos;
    logic [7:0]  biasNeg;
    logic [7:0]  loffPos;
    logic [7:0]  loffNeg;
    logic [7:0]  polSwap;
    logic [7:0]  statPos;
    logic [7:0]  statNeg;
    logic [31:0] rdata;
    logic        ready;
    logic        err;
  } blsr_state_t;

  blsr_state_t st_reg;
  blsr_state_t st_next;
  logic [7:0]  chanMask;
  logic        setupPhase;
  logic        commitWr;
  logic        hit;
  logic [7:0]  wbyte;
  logic [7:0]  rbyte;

  blsr_chmask u_mask (
    .chanCount (CHAN_COUNT),
    .chanMask  (chanMask)
  );

  // answer in the access cycle right after setup: one wait-free cycle
  assign setupPhase = psel && !penable;
  // writes land only at the edge that ends the access phase
  assign commitWr   = psel && penable && st_reg.ready && pwrite;
  assign wbyte      = pstrb[0] ? pwdata[7:0] : 8'h00;

  always_comb begin
    hit   = 1'b1;
    rbyte = 8'h00;
    unique case (paddr[11:2])
      blsr_pkg::byte_addr(blsr_pkg::IDX_BIAS_POS) >> 2: rbyte = st_reg.biasPos;
      blsr_pkg::byte_addr(blsr_pkg::IDX_BIAS_NEG) >> 2: rbyte = st_reg.biasNeg;
      blsr_pkg::byte_addr(blsr_pkg::IDX_LOFF_POS) >> 2: rbyte = st_reg.loffPos;
      blsr_pkg::byte_addr(blsr_pkg::IDX_LOFF_NEG) >> 2: rbyte = st_reg.loffNeg;
      blsr_pkg::byte_addr(blsr_pkg::IDX_POL_SWAP) >> 2: rbyte = st_reg.polSwap;
      blsr_pkg::byte_addr(blsr_pkg::IDX_LEADOFF_POSITIVE_STATUS) >> 2:
        rbyte = st_reg.statPos;
      blsr_pkg::byte_addr(blsr_pkg::IDX_LEADOFF_NEGATIVE_STATUS) >> 2:
        rbyte = st_reg.statNeg;
      default: hit = 1'b0;
    endcase
  end

  always_comb begin
    st_next       = st_reg;
    st_next.statPos = electrodeOffPos & chanMask;
    st_next.statNeg = electrodeOffNeg & chanMask;
    st_next.ready = setupPhase;
    st_next.err   = setupPhase && !hit;
    st_next.rdata = 32'h0000_0000;
    if (setupPhase && !pwrite && hit) begin
      st_next.rdata = {24'h00_0000, rbyte};
    end
    // read-only status and unmapped writes are refused with an error
    if (setupPhase && pwrite) begin
      if (paddr[11:2] == 10'(blsr_pkg::IDX_LEADOFF_POSITIVE_STATUS) ||
          paddr[11:2] == 10'(blsr_pkg::IDX_LEADOFF_NEGATIVE_STATUS)) begin
        st_next.err = 1'b1;
      end
    end
    if (commitWr) begin
      unique case (paddr[11:2])
        10'(blsr_pkg::IDX_BIAS_POS): st_next.biasPos = wbyte & chanMask;
        10'(blsr_pkg::IDX_BIAS_NEG): st_next.biasNeg = wbyte & chanMask;
        10'(blsr_pkg::IDX_LOFF_POS): st_next.loffPos = wbyte & chanMask;
        10'(blsr_pkg::IDX_LOFF_NEG): st_next.loffNeg = wbyte & chanMask;
        10'(blsr_pkg::IDX_POL_SWAP): st_next.polSwap = wbyte & chanMask;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs: registered values, pulls decoded from the swap register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      biasRoutePos    <= blsr_pkg::RST_VAL;
      biasRouteNeg    <= blsr_pkg::RST_VAL;
      leadoffEnPos    <= blsr_pkg::RST_VAL;
      leadoffEnNeg    <= blsr_pkg::RST_VAL;
      pullPosToSupply <= blsr_pkg::RST_VAL;
      pullNegToSupply <= blsr_pkg::RST_VAL;
    end else begin
      biasRoutePos    <= st_next.biasPos;
      biasRouteNeg    <= st_next.biasNeg;
      leadoffEnPos    <= st_next.loffPos;
      leadoffEnNeg    <= st_next.loffNeg;
      pullPosToSupply <= ~st_next.polSwap & chanMask;
      pullNegToSupply <= st_next.polSwap;
    end
  end

  assign prdata  = st_reg.rdata;
  assign pready  = st_reg.ready;
  assign pslverr = st_reg.err;

  property p_route_reset;
    @(posedge clk) disable iff (!rst_n)
      $rose(rst_n) |-> biasRoutePos == 8'h00;
  endproperty
  a_route_reset: assert property (p_route_reset)
    else $error("bias route not zero after reset");

  property p_write_pos;
    @(posedge clk) disable iff (!rst_n)
      (commitWr && paddr[11:2] == 10'(blsr_pkg::IDX_BIAS_POS) && pstrb[0])
      |=> biasRoutePos == ($past(pwdata[7:0]) & chanMask);
  endproperty
  a_write_pos: assert property (p_write_pos)
    else $error("positive route write not applied");

  property p_write_neg;
    @(posedge clk) disable iff (!rst_n)
      (commitWr && paddr[11:2] == 10'(blsr_pkg::IDX_BIAS_NEG) && pstrb[0])
      |=> biasRouteNeg == ($past(pwdata[7:0]) & chanMask);
  endproperty
  a_write_neg: assert property (p_write_neg)
    else $error("negative route write not applied");

  property p_write_lp;
    @(posedge clk) disable iff (!rst_n)
      (commitWr && paddr[11:2] == 10'(blsr_pkg::IDX_LOFF_POS) && pstrb[0])
      |=> leadoffEnPos == ($past(pwdata[7:0]) & chanMask);
  endproperty
  a_write_lp: assert property (p_write_lp)
    else $error("positive lead-off enable write not applied");

  property p_write_ln;
    @(posedge clk) disable iff (!rst_n)
      (commitWr && paddr[11:2] == 10'(blsr_pkg::IDX_LOFF_NEG) && pstrb[0])
      |=> leadoffEnNeg == ($past(pwdata[7:0]) & chanMask);
  endproperty
  a_write_ln: assert property (p_write_ln)
    else $error("negative lead-off enable write not applied");

  property p_write_swap;
    @(posedge clk) disable iff (!rst_n)
      (commitWr && paddr[11:2] == 10'(blsr_pkg::IDX_POL_SWAP) && pstrb[0])
      |=> pullNegToSupply == ($past(pwdata[7:0]) & chanMask);
  endproperty
  a_write_swap: assert property (p_write_swap)
    else $error("polarity swap write not applied");

  // pulls leave reset at zero and settle one edge later, hence the guard
  property p_swap;
    @(posedge clk) disable iff (!rst_n)
      $past(rst_n) |->
        (pullNegToSupply & ~chanMask) == 8'h00 &&
        ((pullPosToSupply ^ pullNegToSupply) == chanMask);
  endproperty
  a_swap: assert property (p_swap)
    else $error("pull directions not complementary");

  property p_status;
    @(posedge clk) disable iff (!rst_n)
      $past(rst_n) |->
        st_reg.statPos == ($past(electrodeOffPos) & chanMask);
  endproperty
  a_status: assert property (p_status)
    else $error("positive status does not follow electrode inputs");

  property p_absent;
    @(posedge clk) disable iff (!rst_n)
      ((biasRoutePos | biasRouteNeg | leadoffEnPos | leadoffEnNeg)
       & ~chanMask) == 8'h00;
  endproperty
  a_absent: assert property (p_absent)
    else $error("absent channel bit set");

  property p_ready_one;
    @(posedge clk) disable iff (!rst_n)
      setupPhase |=> pready ##1 !pready;
  endproperty
  a_ready_one: assert property (p_ready_one)
    else $error("pready not a single cycle");
endmodule
`default_nettype wire

// File: blsr_pkg.sv
// Purpose: constants for the bias and lead-off select register bank
// Assumes: APB, 32-bit data, registers at word index times four
// Notes:   offsets below are register indices, not byte addresses
package blsr_pkg;
  localparam int          REG_W          = 8;
  localparam int          CH_MAX         = 8;
  localparam logic [7:0]  IDX_BIAS_POS   = 8'h0d;
  localparam logic [7:0]  IDX_BIAS_NEG   = 8'h0e;
  localparam logic [7:0]  IDX_LOFF_POS   = 8'h0f;
  localparam logic [7:0]  IDX_LOFF_NEG   = 8'h10;
  localparam logic [7:0]  IDX_POL_SWAP   = 8'h11;
  localparam logic [7:0]  IDX_LEADOFF_POSITIVE_STATUS = 8'h12;
  localparam logic [7:0]  IDX_LEADOFF_NEGATIVE_STATUS = 8'h13;
  localparam logic [7:0]  RST_VAL        = 8'h00;
  localparam logic [7:0]  MASK_CH8       = 8'hff;
  localparam logic [7:0]  MASK_CH6       = 8'h3f;
  localparam logic [7:0]  MASK_CH4       = 8'h0f;
  localparam logic [1:0]  FREQ_AC        = 2'b01;
  localparam logic [1:0]  FREQ_DC        = 2'b11;
  function automatic logic [9:0] byte_addr(input logic [7:0] idx);
    byte_addr = {idx, 2'b00};
  endfunction
endpackage

// File: blsr_chmask.sv
// Purpose: mask of channel bits present in the chosen variant
// Assumes: channel count is 4, 6 or 8
// Notes:   unknown counts fall back to eight channels
`timescale 1ns/1ps
`default_nettype none
module blsr_chmask (
  input  wire logic [3:0] chanCount,
  output logic      [7:0] chanMask
);
  always_comb begin
    unique case (chanCount)
      4'h4:    chanMask = blsr_pkg::MASK_CH4;
      4'h6:    chanMask = blsr_pkg::MASK_CH6;
      default: chanMask = blsr_pkg::MASK_CH8;
    endcase
  end
endmodule
`default_nettype wire

// File: blsr_apb_host.sv
// Purpose: host controller model, APB master for the register bank
// Assumes: one clock, zero or more wait states at the slave
// Notes:   released address and data show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module blsr_apb_host (
  input  wire logic        clk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  output logic      [3:0]  pstrb
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
  end
  // issues reads and writes, never acts on status
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no cycle count assumed: only the bench watchdog ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// File: tb_bias_leadoff_select_regs.sv
// Purpose: self-checking bench of the register bank, six-channel variant
// Assumes: 125 MHz clock, async active-low reset
// Notes:   a four-channel copy shares the bus; eight channels not built
`timescale 1ns/1ps
`default_nettype none
module tb_bias_leadoff_select_regs;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] pstrb;
  logic [7:0] offPos, offNeg, bp, bn, lp, ln, pullP, pullN, bp4, ln4;
  int errors, comparisons;
  blsr_apb_host host (.clk(clk), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
  blsr_bias_leadoff_regs #(.CHAN_COUNT(4'h6)) dut (.clk(clk),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .electrodeOffPos(offPos),
    .electrodeOffNeg(offNeg), .biasRoutePos(bp), .biasRouteNeg(bn),
    .leadoffEnPos(lp), .leadoffEnNeg(ln), .pullPosToSupply(pullP),
    .pullNegToSupply(pullN));
  blsr_bias_leadoff_regs #(.CHAN_COUNT(4'h4)) dut4 (.clk(clk),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(),
    .pready(), .pslverr(), .electrodeOffPos(offPos),
    .electrodeOffNeg(offNeg), .biasRoutePos(bp4), .biasRouteNeg(),
    .leadoffEnPos(), .leadoffEnNeg(ln4), .pullPosToSupply(),
    .pullNegToSupply());
  function automatic logic [7:0] cfg_out(input int i);
    case (i)
      0:       cfg_out = bp;
      1:       cfg_out = bn;
      2:       cfg_out = lp;
      3:       cfg_out = ln;
      default: cfg_out = pullN;
    endcase
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    comparisons++;
    if (s !== x) begin
      errors++;
      $display("[ERR] %0t got %h want %h", $time, s, x);
    end
  endtask
  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic t_reset();
    for (int i = 0; i < 5; i++) begin
      host.xfer(1'b0, 12'h034 + 12'(4 * i), 32'h0, q, e);
      chk(q, 32'h0);
    end
    chk(pullP, 8'h3f);
  endtask
  task automatic t_rw(input logic [7:0] v);
    for (int i = 0; i < 5; i++) begin
      host.xfer(1'b1, 12'h034 + 12'(4 * i), {24'h0, v}, q, e);
      chk(e, 1'b0);
      @(negedge clk);
      chk(cfg_out(i), v & 8'h3f);
      host.xfer(1'b0, 12'h034 + 12'(4 * i), 32'h0, q, e);
      chk(q, {24'h0, v & 8'h3f});
    end
    chk(pullP, ~v & 8'h3f);
    chk(bp4, v & 8'h0f);
    chk(ln4, v & 8'h0f);
  endtask
  task automatic t_status();
    @(posedge clk);
    offPos <= 8'hff;
    offNeg <= 8'h81;
    repeat (2) @(posedge clk);
    host.xfer(1'b0, 12'h048, 32'h0, q, e);
    chk(q, 32'h3f);
    host.xfer(1'b0, 12'h04c, 32'h0, q, e);
    chk(q, 32'h01);
  endtask
  task automatic t_err();
    host.xfer(1'b0, 12'h000, 32'h0, q, e);
    chk(e, 1'b1);
    host.xfer(1'b1, 12'h048, 32'h00, q, e);
    chk(e, 1'b1);
    host.xfer(1'b0, 12'h048, 32'h0, q, e);
    chk(q, 32'h3f);
    host.xfer(1'b1, 12'h0fc, 32'h0, q, e);
    chk(e, 1'b1);
    host.xfer(1'b0, 12'h034, 32'h0, q, e);
    chk(q, 32'h16);
  endtask
  task automatic t_midreset();
    @(posedge clk);
    rst_n <= 1'b0;
    @(negedge clk);
    chk(bp, 8'h00);
    chk(pullN, 8'h00);
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #100000;
    errors++;
    report_and_stop();
  end
  initial begin
    rst_n = 1'b0;
    offPos = 8'h00;
    offNeg = 8'h00;
    errors = 0;
    comparisons = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    t_reset();
    t_rw(8'hff);
    t_rw(8'h96);
    t_status();
    t_err();
    t_midreset();
    report_and_stop();
  end
endmodule
`default_nettype wire
